// file: hw/ots_sequencer.sv
// module: mode sequencer and tilt comparator of a one-shot accelerometer
`timescale 1ns/1ps

// Overview of operation
// - enable low: shutdown, outputs released
// - enable rise: activate, sample three axes once
// - tilt flags held zero while active
// - samples offset and gain corrected
// - flag high when magnitude exceeds threshold
// - active falls to standby without host
// - flags and data offered only in standby
// - stored flags and data held until mode change
// - each new enable rise gives one acquisition
// - data ready only after active stage ends
// - never drive bus clock low
// - bus line glitches up to 50 ns rejected
// - outputs valid within 900 us of enable
module ots_sequencer
  import ots_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable_pin,
  input wire ots_axes_t raw_sample,
  input wire logic conv_done,
  input wire ots_trim_t trim_x,
  input wire ots_trim_t trim_y,
  input wire ots_trim_t trim_z,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sensor_power_on,
  output logic conv_start,
  output logic [2:0] tilt_flags,
  output logic [2:0] tilt_flags_oe,
  output ots_axes_t sample_data,
  output logic data_ready,
  output logic scl_out,
  output logic scl_oe,
  output logic scl_filt,
  output logic sda_filt
);

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [2:0] sync1_d, sync1_q, sync2_d, sync2_q;
  logic en_prev_d, en_prev_q;

  always_comb
  begin
    sync1_d = {enable_pin, scl_in, sda_in};
    sync2_d = sync1_q;
    en_prev_d = sync2_q[2];
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      en_prev_q <= 1'h0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      en_prev_q <= en_prev_d;
    end
  end

  logic en_s, en_rise;
  assign en_s = sync2_q[2];
  assign en_rise = en_s && !en_prev_q;

  // ****************************************
  // bus line glitch filter
  // ****************************************
  logic [1:0] filt_d, filt_q, cand_d, cand_q;
  logic [3:0] fcnt0_d, fcnt0_q, fcnt1_d, fcnt1_q;

  // one bus line of the filter
  function automatic void filt_step(
    input logic line_now,
    input logic line_cand,
    input logic [3:0] cnt,
    input logic filt_now,
    output logic [3:0] cnt_next,
    output logic filt_next
  );
    cnt_next = cnt;
    filt_next = filt_now;
    if (line_now != line_cand) cnt_next = 4'h0;
    else if (cnt < 4'(GLITCH_REJECT_CYC)) cnt_next = cnt + 4'h1;
    else filt_next = line_cand;
  endfunction : filt_step

  always_comb
  begin
    cand_d = sync2_q[1:0];
    // a level must persist past the reject width to be accepted
    filt_step(sync2_q[0], cand_q[0], fcnt0_q, filt_q[0], fcnt0_d, filt_d[0]);
    filt_step(sync2_q[1], cand_q[1], fcnt1_q, filt_q[1], fcnt1_d, filt_d[1]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      filt_q <= 2'h3;
      cand_q <= 2'h3;
      fcnt0_q <= 4'h0;
      fcnt1_q <= 4'h0;
    end
    else
    begin
      filt_q <= filt_d;
      cand_q <= cand_d;
      fcnt0_q <= fcnt0_d;
      fcnt1_q <= fcnt1_d;
    end
  end

  assign sda_filt = filt_q[0];
  assign scl_filt = filt_q[1];
  // the clock line is only ever sampled, never held low
  assign scl_out = 1'b0;
  assign scl_oe = 1'b0;

  // ****************************************
  // mode sequencer
  // ****************************************
  // turn-on latency is mostly the converter's: this
  // block adds two sync cycles, one edge-detect cycle,
  // one start cycle and one capture cycle around it,
  // so the converter must finish well inside the budget
  ots_state_t state_d, state_q;
  logic started_d, started_q;
  logic [2:0] flags_d, flags_q;
  ots_axes_t data_d, data_q;
  ots_axes_t comp;

  always_comb
  begin
    comp.x = ots_comp(raw_sample.x, trim_x);
    comp.y = ots_comp(raw_sample.y, trim_y);
    comp.z = ots_comp(raw_sample.z, trim_z);
  end

  always_comb
  begin
    state_d = state_q;
    started_d = started_q;
    flags_d = flags_q;
    data_d = data_q;
    unique case (state_q)
      ST_SHUTDOWN:
      begin
        started_d = 1'b0;
        if (en_rise)
        begin
          state_d = ST_ACTIVE;
          flags_d = FLAGS_RESET;
        end
      end
      ST_ACTIVE:
      begin
        started_d = 1'b1;
        if (!en_s) state_d = ST_SHUTDOWN;
        else if (started_q && conv_done)
        begin
          data_d = comp;
          flags_d[0] = ots_abs(comp.x) > TILT_THRESHOLD;
          flags_d[1] = ots_abs(comp.y) > TILT_THRESHOLD;
          flags_d[2] = ots_abs(comp.z) > TILT_THRESHOLD;
          state_d = ST_STANDBY;
        end
      end
      ST_STANDBY:
      begin
        // held here, no new sample until enable falls and rises again
        if (!en_s) state_d = ST_SHUTDOWN;
      end
      default: state_d = ST_SHUTDOWN;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_q <= ST_SHUTDOWN;
      started_q <= 1'b0;
      flags_q <= FLAGS_RESET;
      data_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      started_q <= started_d;
      flags_q <= flags_d;
      data_q <= data_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign sensor_power_on = (state_q == ST_ACTIVE);
  assign conv_start = (state_q == ST_ACTIVE) && !started_q;
  assign data_ready = (state_q == ST_STANDBY);
  assign tilt_flags = (state_q == ST_STANDBY) ? flags_q : 3'h0;
  assign tilt_flags_oe = (state_q == ST_SHUTDOWN) ? 3'h0 : 3'h7;
  assign sample_data = (state_q == ST_STANDBY) ? data_q : '0;

endmodule : ots_sequencer

// file: hw/ots_pkg.sv
// package: constants, types and helpers for the one-shot tilt sequencer
package ots_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam int ACQ_LATENCY_US = 900;
  localparam int ACQ_LATENCY_CYC = (ACQ_LATENCY_US * (CLK_HZ / 1000000));
  localparam int GLITCH_REJECT_NS = 50;
  localparam int CLK_PERIOD_NS = 40;
  localparam int GLITCH_REJECT_CYC =
    (GLITCH_REJECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************
  // sample format and threshold
  // ****************************************
  localparam int SAMPLE_W = 14;
  localparam int NUM_AXES = 3;
  localparam logic [13:0] TILT_THRESHOLD = 14'h02B0;
  localparam logic [13:0] SAMPLE_RESET = 14'h0000;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [7:0] STATUS_ADDR = 8'h00;
  localparam logic [15:0] GAIN_UNITY = 16'h1000;
  localparam int GAIN_FRAC = 12;

  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_STANDBY = 3'b100
  } ots_state_t;

  typedef struct packed {
    logic [13:0] x;
    logic [13:0] y;
    logic [13:0] z;
  } ots_axes_t;

  typedef struct packed {
    logic [13:0] offset;
    logic [15:0] gain;
  } ots_trim_t;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [13:0] ots_abs(input logic [13:0] s);
    ots_abs = s[13] ? 14'(-s) : s;
  endfunction : ots_abs

  function automatic logic [13:0] ots_comp(input logic [13:0] raw, input ots_trim_t t);
    logic signed [14:0] d;
    logic signed [31:0] p;
    d = 15'($signed(raw)) - 15'($signed(t.offset));
    p = 32'(d) * 32'($signed({1'b0, t.gain}));
    ots_comp = 14'(p >>> GAIN_FRAC);
  endfunction : ots_comp

endpackage : ots_pkg

// file: bench/ots_checker.sv
// checker: output timing and relations of the tilt sequencer
`timescale 1ns/1ps
module ots_checker
  import ots_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic enable_pin,
  input wire logic scl_in,
  input wire logic conv_done,
  input wire logic sensor_power_on,
  input wire logic conv_start,
  input wire logic [2:0] tilt_flags,
  input wire logic [2:0] tilt_flags_oe,
  input wire ots_axes_t sample_data,
  input wire logic data_ready,
  input wire logic scl_filt
);
  function automatic logic big(input logic [13:0] s);
    big = (s[13] ? 14'(-s) : s) > 14'h02B0;
  endfunction : big
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_flags_low_active: assert property (sensor_power_on |-> tilt_flags == 3'h0)
    else $error("flags set while active");
  a_shutdown_released: assert property (!enable_pin [*4] |=> tilt_flags_oe == 3'h0)
    else $error("outputs driven in shutdown");
  a_one_start: assert property ($rose(sensor_power_on) |-> conv_start ##1 !conv_start)
    else $error("start not a single pulse");
  a_ready_only_standby: assert property (data_ready |-> !sensor_power_on && &tilt_flags_oe)
    else $error("data offered outside standby");
  a_data_hold: assert property (data_ready && $past(data_ready) |->
    $stable(tilt_flags) && $stable(sample_data))
    else $error("held data changed");
  a_flag_threshold: assert property (data_ready |-> tilt_flags ==
    {big(sample_data.z), big(sample_data.y), big(sample_data.x)})
    else $error("flag disagrees with sample");
  a_auto_standby: assert property (conv_done && sensor_power_on && !conv_start && enable_pin
    |-> ##[1:2] data_ready)
    else $error("no standby after conversion");
  a_glitch_reject: assert property ($changed(scl_filt) |->
    $past(scl_in, 3) == scl_filt && $past(scl_in, 4) == scl_filt)
    else $error("filter passed a short pulse");
endmodule : ots_checker
bind ots_sequencer ots_checker u_ots_checker (.clk_sys, .rst, .enable_pin, .scl_in,
  .conv_done, .sensor_power_on, .conv_start, .tilt_flags, .tilt_flags_oe, .sample_data,
  .data_ready, .scl_filt);

// file: bench/ots_front_model.sv
// model: converter answering each start with one done pulse, sent only if sensor_power_on is still high
`timescale 1ns/1ps
module ots_front_model
(
  input wire logic clk_sys,
  input wire logic conv_start,
  input wire logic sensor_power_on,
  input wire logic [7:0] lat,
  output logic conv_done
);
  logic [7:0] cnt_q = 8'h00;
  initial conv_done = 1'b0;
  always @(posedge clk_sys)
  begin
    conv_done <= (cnt_q == 8'h01) && sensor_power_on;
    cnt_q <= conv_start ? lat : (cnt_q != 8'h00 ? cnt_q - 8'h01 : 8'h00);
  end
endmodule : ots_front_model

// file: bench/ots_sequencer_tb_top.sv
// testbench: acquisitions, threshold corners, abort and bus filter
`timescale 1ns/1ps
module ots_sequencer_tb_top;
  import ots_pkg::*;
  localparam int GAP = 25000;
  logic clk_sys = 1'b0, rst = 1'b1, enable_pin = 1'b0, scl_in = 1'b1, sda_in = 1'b1;
  logic conv_done, sensor_power_on, conv_start, data_ready, scl_out, scl_oe, scl_filt, sda_filt;
  logic [2:0] tilt_flags, tilt_flags_oe;
  logic [7:0] lat = 8'h05;
  ots_axes_t raw_sample = '0, sample_data;
  ots_trim_t trim = '0;
  int n_fail = 0, compares = 0;
  always #20 clk_sys = ~clk_sys;
  ots_sequencer u_ots_sequencer (.clk_sys, .rst, .enable_pin, .raw_sample, .conv_done,
    .trim_x(trim), .trim_y(trim), .trim_z(trim), .scl_in, .sda_in, .sensor_power_on,
    .conv_start, .tilt_flags, .tilt_flags_oe, .sample_data, .data_ready, .scl_out, .scl_oe,
    .scl_filt, .sda_filt);
  ots_front_model u_ots_front_model (.clk_sys, .conv_start, .sensor_power_on, .lat, .conv_done);
  task automatic check(input string what, input logic [41:0] seen, input logic [41:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check
  function automatic logic [13:0] cmp(input logic [13:0] r);
    logic signed [31:0] p;
    p = ($signed(32'(signed'(r))) - 32'(signed'(trim.offset))) * $signed({16'h0, trim.gain});
    cmp = p[25:12];
  endfunction : cmp
  function automatic logic fl(input logic [13:0] c);
    fl = (c[13] ? 14'(-c) : c) > 14'h02B0;
  endfunction : fl
  task automatic acq(input ots_axes_t r, input bit abort);
    ots_axes_t e;
    @(negedge clk_sys);
    raw_sample = r;
    enable_pin = 1'b1;
    for (int i = 0; i < 300 && data_ready !== 1'b1 && !abort; i++)
      @(negedge clk_sys);
    if (abort)
    begin
      repeat (4) @(negedge clk_sys);
      check("active tilt_flags", 42'(tilt_flags), 42'h0);
    end
    if (!abort)
    begin
      e = {cmp(r.x), cmp(r.y), cmp(r.z)};
      check("data_ready", 42'(data_ready), 42'h1);
      check("sample_data", sample_data, e);
      check("tilt_flags", 42'(tilt_flags), 42'({fl(e.z), fl(e.y), fl(e.x)}));
      repeat (10) @(negedge clk_sys);
      check("held sample_data", sample_data, e);
      check("held data_ready", 42'(data_ready), 42'h1);
    end
    enable_pin = 1'b0;
    repeat (5) @(negedge clk_sys);
    check("tilt_flags_oe", 42'(tilt_flags_oe), 42'h0);
    check("data_ready", 42'(data_ready), 42'h0);
    check("sample_data", sample_data, 42'h0);
    repeat (GAP) @(negedge clk_sys);
    $display("acquisition done");
  endtask : acq
  task automatic glitch();
    @(negedge clk_sys);
    {scl_in, sda_in} = 2'b00;
    @(negedge clk_sys);
    {scl_in, sda_in} = 2'b11;
    repeat (8) @(negedge clk_sys);
    check("bus filt", 42'({scl_filt, sda_filt}), 42'h3);
    {scl_in, sda_in} = 2'b00;
    repeat (8) @(negedge clk_sys);
    check("bus filt", 42'({scl_filt, sda_filt}), 42'h0);
    check("scl_oe", 42'({scl_oe, scl_out}), 42'h0);
    {scl_in, sda_in} = 2'b11;
    $display("filter done");
  endtask : glitch
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  initial
  begin
    void'($urandom(89));
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    glitch();
    trim.gain = 16'h1000;
    acq({14'h02B0, 14'h3D50, 14'h3D4F}, 1'b0);
    trim = {14'($urandom_range(0, 80)), 16'($urandom_range(16'h0C00, 16'h13FF))};
    lat = 8'($urandom_range(2, 60));
    acq(42'($urandom()) ^ {42'($urandom()) << 32}, 1'b0);
    lat = 8'hC8;
    acq(42'($urandom()), 1'b1);
    summarize();
  end
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    n_fail++;
    summarize();
  end
endmodule : ots_sequencer_tb_top
